// ### verilog/emb_msg_buffer.sv
// encoder message buffer: tx word assembly, reply fifo, rx word handshake
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps

module emb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // fill side
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  // drain side
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0]   count;
    logic          notFull;
  } emb_fifo_t;

  emb_fifo_t        s;
  emb_fifo_t        next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign inReady  = s.notFull;
  assign outValid = (s.count != '0);
  assign outData  = mem[s.rdPtr];

  always_comb begin
    next_s = s;
    push   = inValid && s.notFull;
    pop    = outValid && outReady;
    if (push) begin
      next_s.wrPtr = (s.wrPtr == AW'(DEPTH - 1)) ? '0 : s.wrPtr + 1'b1;
    end
    if (pop) begin
      next_s.rdPtr = (s.rdPtr == AW'(DEPTH - 1)) ? '0 : s.rdPtr + 1'b1;
    end
    if (push && !pop) begin
      next_s.count = s.count + 1'b1;
    end else if (pop && !push) begin
      next_s.count = s.count - 1'b1;
    end
    next_s.notFull = (next_s.count != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s         <= '0;
      s.notFull <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[s.wrPtr] <= inData;
    end
  end
endmodule

// Function
// - tx word cleared once drive takes it
// - word with bit 14 launches transfer
// - bit 13 first byte, bit 14 last
// - first reply byte in rx low, bit15 set
// - next byte loaded only after software clears
// - eight byte reply, byte five bit7/bit6
// - bytes six to eight hold position, turns
// - three word reply, last has bit 14
module emb_msg_buffer
  import emb_pkg::*;
#(
  parameter int TX_DEPTH = 16,
  parameter int RX_DEPTH = 8
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [31:0]       regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic [31:0]            regRdata,
  // message bytes toward the encoder link
  output logic [7:0]             txByte,
  output logic                   txValid,
  output logic                   txLast,
  input  wire logic              txReady,
  // reply bytes from the encoder link
  input  wire logic [7:0]        rxByte,
  input  wire logic              rxValid,
  input  wire logic              rxLast,
  output logic                   rxReady,
  // position check control
  output logic                   posCheckDisable
);
  localparam int TW = $clog2(TX_DEPTH);

  typedef enum logic [0:0] {ST_IDLE, ST_SEND} emb_state_t;

  typedef struct packed {
    emb_state_t           state;
    logic [15:0]          txWord;
    logic [15:0]          rxWord;
    logic                 posChk;
    logic [TW:0]          txLen;
    logic [TW:0]          sendIdx;
    logic [7:0]           txByte;
    logic                 txValid;
    logic                 txLast;
    logic [7:0]           cmd;
    logic                 posReply;
    logic [2:0]           rxIdx;
    logic [POS_BITS-1:0]  pos;
    logic [TURN_BITS-1:0] turns;
    logic                 alarm;
    logic [31:0]          rdata;
  } emb_top_t;

  emb_top_t   s;
  emb_top_t   next_s;
  logic [7:0] txMem [TX_DEPTH];
  logic       accept;
  logic       first;
  logic       last;
  logic [TW:0] wrIdx;
  logic [8:0] fifoOut;
  logic       fifoValid;
  logic       popReady;
  logic       popFire;
  logic       wrTx;
  logic       wrRx;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction

  // reply bytes wait here so a slow software reader loses nothing
  emb_fifo #(
    .WIDTH (9),
    .DEPTH (RX_DEPTH)
  ) u_rx_fifo (
    .clk      (clk),
    .reset    (reset),
    .inData   ({rxLast, rxByte}),
    .inValid  (rxValid),
    .inReady  (rxReady),
    .outData  (fifoOut),
    .outValid (fifoValid),
    .outReady (popReady)
  );

  assign regRdata        = s.rdata;
  assign txByte          = s.txByte;
  assign txValid         = s.txValid;
  assign txLast          = s.txLast;
  assign posCheckDisable = s.posChk;

  always_comb begin
    next_s   = s;
    wrTx     = regWr && hit(regAddr, ADDR_TX_WORD);
    wrRx     = regWr && hit(regAddr, ADDR_RX_WORD);
    // a word written during a send waits; its nonzero value is the stall
    accept   = (s.txWord != WORD_ZERO) && (s.state == ST_IDLE);
    first    = s.txWord[FIRST_BIT];
    last     = s.txWord[LAST_BIT];
    wrIdx    = first ? '0 : s.txLen;
    popReady = !s.rxWord[VALID_BIT];
    popFire  = popReady && fifoValid;

    if (accept) begin
      next_s.txWord = WORD_ZERO;
      if (wrIdx < (TW+1)'(TX_DEPTH)) begin
        next_s.txLen = wrIdx + 1'b1;
      end
      if (first) begin
        next_s.cmd = s.txWord[7:0];
      end
      if (last) begin
        next_s.state    = ST_SEND;
        next_s.sendIdx  = '0;
        next_s.txValid  = 1'b1;
        next_s.txByte   = (wrIdx == '0) ? s.txWord[7:0] : txMem[0];
        next_s.txLast   = (wrIdx == '0);
        next_s.posReply = ((first ? s.txWord[7:0] : s.cmd)
                           == CMD_READ_POS);
        next_s.rxIdx    = '0;
      end
    end

    if (s.state == ST_SEND && s.txValid && txReady) begin
      if (s.txLast) begin
        next_s.txValid = 1'b0;
        next_s.txLast  = 1'b0;
        next_s.state   = ST_IDLE;
      end else begin
        next_s.sendIdx = s.sendIdx + 1'b1;
        next_s.txByte  = txMem[TW'(s.sendIdx + 1'b1)];
        next_s.txLast  = ((s.sendIdx + 2'd2) == s.txLen);
      end
    end

    if (wrTx) begin
      next_s.txWord = regWdata[15:0];
    end
    if (wrRx) begin
      next_s.rxWord = regWdata[15:0];
    end
    // load beats a clear in the same cycle, so no byte is lost
    if (popFire) begin
      next_s.rxWord = WORD_ZERO;
      next_s.rxWord[VALID_BIT] = 1'b1;
      next_s.rxWord[LAST_BIT]  = fifoOut[8];
      next_s.rxWord[7:0]       = fifoOut[7:0];
      next_s.rxIdx = fifoOut[8] ? '0 : s.rxIdx + 1'b1;
      if (s.posReply) begin
        case (s.rxIdx)
          POS_BYTE_LOW: begin
            next_s.pos[0] = fifoOut[7];
            next_s.alarm  = fifoOut[6];
          end
          POS_BYTE_MID: begin
            next_s.pos[8:1] = fifoOut[7:0];
          end
          POS_BYTE_MIX: begin
            next_s.turns[3:0] = fifoOut[7:4];
            next_s.pos[12:9]  = fifoOut[3:0];
          end
          POS_BYTE_TURNS: begin
            next_s.turns[11:4] = fifoOut[7:0];
          end
          default: begin
            next_s.pos = s.pos;
          end
        endcase
      end
    end

    if (regWr && hit(regAddr, ADDR_POS_CHK)) begin
      next_s.posChk = regWdata[0];
    end

    next_s.rdata = RDATA_ZERO;
    if (regRd) begin
      case (regAddr)
        ADDR_TX_WORD:  next_s.rdata = {16'h0000, s.txWord};
        ADDR_RX_WORD:  next_s.rdata = {16'h0000, s.rxWord};
        ADDR_POS_CHK:  next_s.rdata = {31'h0000_0000, s.posChk};
        ADDR_STATUS:   next_s.rdata = {30'h0000_0000, fifoValid,
                                       (s.state == ST_SEND)};
        ADDR_POSITION: next_s.rdata = {6'h00, s.alarm, s.turns, s.pos};
        default:       next_s.rdata = RDATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s       <= '0;
      s.state <= ST_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // buffered message bytes, written as each of the first TX_DEPTH words of a message is taken
  always_ff @(posedge clk) begin
    if (accept && wrIdx < (TW+1)'(TX_DEPTH)) begin
      txMem[TW'(wrIdx)] <= s.txWord[7:0];
    end
  end

  sequence seq_take_mid;
    accept && !last && !wrTx;
  endsequence

  sequence seq_pop;
    popFire && !wrRx;
  endsequence

  chk_tx_cleared: assert property (@(posedge clk) disable iff (reset)
    accept && !wrTx |=> s.txWord == WORD_ZERO)
    else $error("tx word not cleared after accept");

  chk_launch_on_last: assert property (@(posedge clk) disable iff (reset)
    $rose(s.txValid) |-> $past(accept) && $past(s.txWord[LAST_BIT]))
    else $error("transfer started without last word");

  chk_mid_no_launch: assert property (@(posedge clk) disable iff (reset)
    seq_take_mid |=> !s.txValid)
    else $error("non-last word launched transfer");

  chk_first_restart: assert property (@(posedge clk) disable iff (reset)
    accept && first |=> s.txLen == 1)
    else $error("first word did not restart message");

  chk_rx_load: assert property (@(posedge clk) disable iff (reset)
    seq_pop |=> s.rxWord[VALID_BIT] && s.rxWord[7:0] == $past(fifoOut[7:0]))
    else $error("reply byte not loaded with valid flag");

  chk_rx_hold: assert property (@(posedge clk) disable iff (reset)
    s.rxWord[VALID_BIT] && !wrRx |=> s.rxWord == $past(s.rxWord))
    else $error("rx word changed before software cleared it");

  chk_rx_last: assert property (@(posedge clk) disable iff (reset)
    seq_pop |=> s.rxWord[LAST_BIT] == $past(fifoOut[8]))
    else $error("last flag of reply word wrong");

  chk_turns_high: assert property (@(posedge clk) disable iff (reset)
    popFire && s.posReply && s.rxIdx == POS_BYTE_TURNS
    |=> s.turns[11:4] == $past(fifoOut[7:0]))
    else $error("turns high byte not captured");

  chk_tx_drains: assert property (@(posedge clk) disable iff (reset)
    wrTx ##1 (s.state == ST_IDLE && !wrTx) |=> s.txWord == WORD_ZERO)
    else $error("idle drive did not take the word");

  chk_single_byte: assert property (@(posedge clk) disable iff (reset)
    accept && first && last |=> s.txValid && s.txLast)
    else $error("single byte message not marked last");

  chk_pos_low: assert property (@(posedge clk) disable iff (reset)
    popFire && s.posReply && s.rxIdx == POS_BYTE_LOW
    |=> s.pos[0] == $past(fifoOut[7]) && s.alarm == $past(fifoOut[6]))
    else $error("position bit 0 or alarm not captured");

  chk_send_done: assert property (@(posedge clk) disable iff (reset)
    s.txValid && s.txLast && txReady |=> !s.txValid)
    else $error("transfer kept going after last byte");
endmodule

// ### shared/emb_pkg.sv
// constants for the encoder message buffer
package emb_pkg;
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  ADDR_TX_WORD    = 8'h00;
  localparam logic [7:0]  ADDR_RX_WORD    = 8'h04;
  localparam logic [7:0]  ADDR_POS_CHK    = 8'h08;
  localparam logic [7:0]  ADDR_STATUS     = 8'h0C;
  localparam logic [7:0]  ADDR_POSITION   = 8'h10;
  localparam int          VALID_BIT       = 15;
  localparam int          LAST_BIT        = 14;
  localparam int          FIRST_BIT       = 13;
  localparam logic [7:0]  CMD_READ_POS    = 8'h00;
  localparam logic [2:0]  POS_BYTE_LOW    = 3'h4;
  localparam logic [2:0]  POS_BYTE_MID    = 3'h5;
  localparam logic [2:0]  POS_BYTE_MIX    = 3'h6;
  localparam logic [2:0]  POS_BYTE_TURNS  = 3'h7;
  localparam int          POS_BITS        = 13;
  localparam int          TURN_BITS       = 12;
  localparam logic [15:0] WORD_ZERO       = 16'h0000;
  localparam logic [31:0] RDATA_ZERO      = 32'h0000_0000;
endpackage

// ### testbench/emb_link_model.sv
// encoder-side link model: takes message bytes, answers with a reply
`timescale 1ns/10ps

module emb_link_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // stall control, toggles txReady when high
  input  wire logic        slow,
  // message bytes from the buffer
  input  wire logic [7:0]  txByte,
  input  wire logic        txValid,
  input  wire logic        txLast,
  output logic             txReady,
  // reply bytes to the buffer
  output logic [7:0]       rxByte,
  output logic             rxValid,
  output logic             rxLast,
  input  wire logic        rxReady,
  // record of the last message
  output logic [31:0]      msg,
  output logic [3:0]       msgLen
);
  logic [7:0] posRep [8] = '{8'h00, 8'h00, 8'h00, 8'h00,
                             8'h00, 8'h9f, 8'h4e, 8'h74};
  logic [7:0] parRep [3] = '{8'h00, 8'h12, 8'h34};
  logic [7:0] cmd;
  logic [7:0] prev;
  logic [3:0] idx;
  logic [3:0] n;
  logic       fresh;
  assign rxValid = idx < n;
  assign rxLast  = rxValid && idx == n - 4'h1;
  // idle line shows the inverse of the last byte, never a stale copy
  assign rxByte  = !rxValid ? ~prev :
                   (n == 4'h8 ? posRep[idx[2:0]] : parRep[idx[1:0]]);
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      txReady <= 1'b0;
      idx <= 4'h0;
      n <= 4'h0;
      prev <= 8'h00;
      fresh <= 1'b1;
      msg <= 32'h0000_0000;
      msgLen <= 4'h0;
      cmd <= 8'h00;
    end else begin
      txReady <= slow ? ~txReady : 1'b1;
      if (rxValid && rxReady) begin
        idx <= idx + 4'h1;
        prev <= rxByte;
      end
      if (txValid && txReady) begin
        msg <= fresh ? {24'h00_0000, txByte} : {msg[23:0], txByte};
        msgLen <= fresh ? 4'h1 : msgLen + 4'h1;
        fresh <= txLast;
        if (fresh) cmd <= txByte;
        if (txLast) begin
          n <= ((fresh ? txByte : cmd) == 8'h00) ? 4'h8 : 4'h3;
          idx <= 4'h0;
        end
      end
    end
  end
endmodule

// ### testbench/emb_msg_buffer_test.sv
// self-checking bench for the encoder message buffer
`timescale 1ns/10ps

module emb_msg_buffer_test;
  import emb_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0000_0000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        slow = 1'b0;
  logic [31:0] regRdata, msg, d;
  logic [7:0]  txByte, rxByte;
  logic        txValid, txLast, txReady, rxValid, rxLast, rxReady;
  logic        posCheckDisable;
  logic [3:0]  msgLen;
  int          errors = 0;
  int          checkCount = 0;
  int          cycles = 0;
  logic [15:0] posW [$] = '{16'h8000, 16'h8000, 16'h8000, 16'h8000,
                            16'h8000, 16'h809f, 16'h804e, 16'hc074};
  logic [15:0] parW [$] = '{16'h8000, 16'h8012, 16'hc034};

  always #5 clk = ~clk;

  emb_msg_buffer uut (.clk(clk), .reset(reset), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .txByte(txByte), .txValid(txValid), .txLast(txLast), .txReady(txReady),
    .rxByte(rxByte), .rxValid(rxValid), .rxLast(rxLast), .rxReady(rxReady),
    .posCheckDisable(posCheckDisable));

  emb_link_model model (.clk(clk), .reset(reset), .slow(slow),
    .txByte(txByte), .txValid(txValid), .txLast(txLast), .txReady(txReady),
    .rxByte(rxByte), .rxValid(rxValid), .rxLast(rxLast), .rxReady(rxReady),
    .msg(msg), .msgLen(msgLen));

  task automatic results;
    if (errors == 0 && checkCount > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // extra edge after the strobe so back-to-back calls never collide
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    v = regRdata;
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
  endtask

  task automatic poll(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] v);
    int k;
    for (k = 0; k < 40; k++) begin
      rd(a, d);
      if ((d & m) === v) break;
    end
    chk(d & m, v);
  endtask

  task automatic send(input logic [15:0] w [$]);
    foreach (w[i]) begin
      wr(ADDR_TX_WORD, {16'h0000, w[i]});
      poll(ADDR_TX_WORD, 32'h0000_ffff, 32'h0000_0000);
      if (i < w.size() - 1) chk(32'(txValid), 32'h0000_0000);
    end
    poll(ADDR_STATUS, 32'h0000_0001, 32'h0000_0000);
  endtask

  task automatic recv(input logic [15:0] w [$]);
    foreach (w[i]) begin
      poll(ADDR_RX_WORD, 32'h0000_8000, 32'h0000_8000);
      chk(d, {16'h0000, w[i]});
      rdchk(ADDR_RX_WORD, {16'h0000, w[i]});
      wr(ADDR_RX_WORD, 32'h0000_0000);
    end
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rdchk(ADDR_TX_WORD, 32'h0000_0000);
    rdchk(ADDR_RX_WORD, 32'h0000_0000);
    rdchk(ADDR_STATUS, 32'h0000_0000);
    wr(8'h14, 32'h0000_ffff);
    rdchk(8'h14, 32'h0000_0000);
    wr(ADDR_POS_CHK, 32'h0000_0001);
    chk(32'(posCheckDisable), 32'h0000_0001);
    rdchk(ADDR_POS_CHK, 32'h0000_0001);
    send('{16'ha000, 16'hc000});
    chk({msg[15:0], 12'h000, msgLen}, 32'h0000_0002);
    // second request with the first reply undrained fills the fifo
    slow <= 1'b1;
    send('{16'ha003, 16'h8000, 16'h8000, 16'hc000});
    chk(msg, 32'h0300_0000);
    chk(32'(msgLen), 32'h0000_0004);
    repeat (40) if (rxReady !== 1'b0) @(posedge clk);
    chk(32'(rxReady), 32'h0000_0000);
    rdchk(ADDR_STATUS, 32'h0000_0002);
    recv(posW);
    recv(parW);
    slow <= 1'b0;
    wr(ADDR_POS_CHK, 32'h0000_0000);
    chk(32'(posCheckDisable), 32'h0000_0000);
    rdchk(ADDR_POS_CHK, 32'h0000_0000);
    send('{16'he000});
    chk(32'(msgLen), 32'h0000_0001);
    recv(posW);
    rdchk(ADDR_POSITION, 32'h00e8_9d3e);
    rdchk(ADDR_STATUS, 32'h0000_0000);
    results();
  end
endmodule
